// ### asc_step_five_config.sv
// configuration register and applied selects for sequencer step five
`timescale 1ns/10ps

// Overview of operation
// - step takes part in the sequence only while step_enable is set; otherwise skipped.
// - gain field 00 gives x1, 01 gives x2, 10 and 11 give x4.
// - bits 12:5 always read zero and ignore writes.
// - negative input bit 0 picks analog ground, 1 picks analog input seven.
// - positive codes 0 to 7 pick external inputs 0 to 7 in order.
// - codes 8, 9, 10 pick temperature sensor, internal short, test DAC.
// - codes 11, 14, 15 pick supply monitors; 12 and 13 flagged unconfirmed.
// - positive codes 8 and above choose negative input automatically, ignoring the bit.
// - reset clears enable, gain and negative bit, loads positive code five.
module asc_step_five_config (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // sequencer handshake
  input  wire logic        step_arrive_i,
  input  wire logic        conv_done_i,
  output logic             step_go_o,
  output logic             step_skip_o,
  output logic             conv_busy_o,
  // gain
  output logic      [1:0]  gain_log2_o,
  // positive input
  output logic      [7:0]  pos_ext_sel_o,
  output logic             pos_temp_sel_o,
  output logic             pos_short_sel_o,
  output logic             pos_test_dac_sel_o,
  output logic             pos_asup_div4_sel_o,
  output logic             pos_apin_sel_o,
  output logic             pos_dpin_sel_o,
  output logic             pos_unsure_sel_o,
  // negative input
  output logic             neg_auto_o,
  output logic             neg_ground_sel_o,
  output logic             neg_input7_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0]           cfg;
  logic [15:0]           applied;
  asc_pkg::asc_state_t   state;
  asc_pkg::asc_state_t   next_state;
  wire logic             hit_cfg;
  wire logic             hit_applied;
  wire logic             cfg_wr;
  wire logic [15:0]      next_cfg;
  wire logic [15:0]      rd_word;
  wire logic             accept;
  wire logic             start_conv;
  wire logic             skip_step;
  wire logic [1:0]       gain_field;
  wire logic [1:0]       next_gain;
  wire logic [7:0]       dec_ext;
  wire logic             dec_temp;
  wire logic             dec_short;
  wire logic             dec_tdac;
  wire logic             dec_asup;
  wire logic             dec_apin;
  wire logic             dec_dpin;
  wire logic             dec_unsure;
  wire logic             dec_auto;
  wire logic             dec_gnd;
  wire logic             dec_in7;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  assign hit_cfg     = reg_addr_i == asc_pkg::CFG_ADDR;
  assign hit_applied = reg_addr_i == asc_pkg::APPLIED_ADDR;
  assign cfg_wr      = reg_wr_i && hit_cfg;
  assign next_cfg    = reg_wdata_i & asc_pkg::WR_MASK;
  assign rd_word     = hit_cfg     ? (cfg & asc_pkg::WR_MASK)
                     : hit_applied ? applied
                     : asc_pkg::ZERO_WORD;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cfg <= asc_pkg::CFG_RST;
    else if (cfg_wr)
      cfg <= next_cfg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= asc_pkg::ZERO_WORD;
    else if (reg_rd_i)
      reg_rdata_o <= rd_word;
    else
      reg_rdata_o <= asc_pkg::ZERO_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // step arrival and conversion tracking
  assign accept     = step_arrive_i && (state == asc_pkg::ASC_IDLE);
  assign start_conv = accept && cfg[asc_pkg::EN_BIT];
  assign skip_step  = accept && !cfg[asc_pkg::EN_BIT];

  always_comb
  begin
    next_state = state;
    case (state)
      asc_pkg::ASC_IDLE:
        if (start_conv)
          next_state = asc_pkg::ASC_CONV;
      asc_pkg::ASC_CONV:
        if (conv_done_i)
          next_state = asc_pkg::ASC_IDLE;
      default:
        next_state = asc_pkg::ASC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state       <= asc_pkg::ASC_IDLE;
      conv_busy_o <= 1'b0;
      step_go_o   <= 1'b0;
      step_skip_o <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      conv_busy_o <= next_state == asc_pkg::ASC_CONV;
      step_go_o   <= start_conv;
      step_skip_o <= skip_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  assign gain_field = cfg[asc_pkg::GAIN_HI:asc_pkg::GAIN_LO];
  assign next_gain  = (gain_field == asc_pkg::GAIN_CODE_X1) ? asc_pkg::GAIN_LOG2_X1
                    : (gain_field == asc_pkg::GAIN_CODE_X2) ? asc_pkg::GAIN_LOG2_X2
                    : asc_pkg::GAIN_LOG2_X4;

  asc_input_decode u_decode (
    .pos_code_i       (cfg[asc_pkg::POS_HI:asc_pkg::POS_LO]),
    .neg_bit_i        (cfg[asc_pkg::NEG_BIT]),
    .ext_sel_o        (dec_ext),
    .temp_sel_o       (dec_temp),
    .short_sel_o      (dec_short),
    .test_dac_sel_o   (dec_tdac),
    .asup_div4_sel_o  (dec_asup),
    .apin_sel_o       (dec_apin),
    .dpin_sel_o       (dec_dpin),
    .unsure_sel_o     (dec_unsure),
    .neg_auto_o       (dec_auto),
    .neg_ground_sel_o (dec_gnd),
    .neg_input7_sel_o (dec_in7)
  );

  ////////////////////////////////////////////////////////////////////////////
  // applied selects, loaded only when an enabled step starts
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      applied <= asc_pkg::APPLIED_RST;
    else if (start_conv)
      applied <= cfg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      gain_log2_o   <= asc_pkg::GAIN_LOG2_X1;
      pos_ext_sel_o <= asc_pkg::EXT_NONE;
    end
    else if (start_conv)
    begin
      gain_log2_o   <= next_gain;
      pos_ext_sel_o <= dec_ext;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_temp_sel_o      <= 1'b0;
      pos_short_sel_o     <= 1'b0;
      pos_test_dac_sel_o  <= 1'b0;
      pos_asup_div4_sel_o <= 1'b0;
      pos_apin_sel_o      <= 1'b0;
      pos_dpin_sel_o      <= 1'b0;
      pos_unsure_sel_o    <= 1'b0;
    end
    else if (start_conv)
    begin
      pos_temp_sel_o      <= dec_temp;
      pos_short_sel_o     <= dec_short;
      pos_test_dac_sel_o  <= dec_tdac;
      pos_asup_div4_sel_o <= dec_asup;
      pos_apin_sel_o      <= dec_apin;
      pos_dpin_sel_o      <= dec_dpin;
      pos_unsure_sel_o    <= dec_unsure;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      neg_auto_o       <= 1'b0;
      neg_ground_sel_o <= 1'b0;
      neg_input7_sel_o <= 1'b0;
    end
    else if (start_conv)
    begin
      neg_auto_o       <= dec_auto;
      neg_ground_sel_o <= dec_gnd;
      neg_input7_sel_o <= dec_in7;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  step_enable_gate_a: assert property (
    step_arrive_i && (state == asc_pkg::ASC_IDLE)
    |=> (step_go_o == $past(cfg[asc_pkg::EN_BIT])) && (step_skip_o != step_go_o))
    else $error("step go or skip does not follow the enable bit");

  gain_map_a: assert property (
    start_conv
    |=> gain_log2_o == (($past(gain_field) == asc_pkg::GAIN_CODE_X1) ? asc_pkg::GAIN_LOG2_X1
      : ($past(gain_field) == asc_pkg::GAIN_CODE_X2) ? asc_pkg::GAIN_LOG2_X2
      : asc_pkg::GAIN_LOG2_X4))
    else $error("applied gain does not match gain field");

  reserved_read_a: assert property (
    reg_rd_i && hit_cfg
    |=> reg_rdata_o[asc_pkg::RSV_HI:asc_pkg::RSV_LO] == '0)
    else $error("reserved bits read nonzero");

  neg_select_a: assert property (
    start_conv && (cfg[asc_pkg::POS_HI:asc_pkg::POS_LO] < asc_pkg::POS_INT_MIN)
    |=> neg_input7_sel_o == $past(cfg[asc_pkg::NEG_BIT])
        && neg_ground_sel_o == !$past(cfg[asc_pkg::NEG_BIT]) && !neg_auto_o)
    else $error("negative input select wrong for external source");

  ext_route_a: assert property (
    start_conv && !cfg[asc_pkg::POS_HI]
    |=> $onehot(pos_ext_sel_o) && pos_ext_sel_o[$past(cfg[2:0])])
    else $error("external input not routed by code");

  internal_src_a: assert property (
    start_conv && (cfg[asc_pkg::POS_HI:asc_pkg::POS_LO] == asc_pkg::POS_SHORT)
    |=> pos_short_sel_o && !pos_temp_sel_o && !pos_test_dac_sel_o && pos_ext_sel_o == asc_pkg::EXT_NONE)
    else $error("internal short not selected alone");

  supply_mon_a: assert property (
    start_conv && (cfg[asc_pkg::POS_HI:asc_pkg::POS_LO] == asc_pkg::POS_DPIN)
    |=> pos_dpin_sel_o && !pos_apin_sel_o && !pos_asup_div4_sel_o)
    else $error("digital power monitor not selected");

  neg_auto_a: assert property (
    start_conv && cfg[asc_pkg::POS_HI]
    |=> neg_auto_o && !neg_ground_sel_o && !neg_input7_sel_o)
    else $error("negative input not automatic for internal source");

  reset_value_a: assert property (
    $fell(sys_rst_i) |-> cfg == asc_pkg::CFG_RST)
    else $error("configuration reset value wrong");

  hold_in_conv_a: assert property (
    conv_busy_o && !conv_done_i
    |=> $stable(gain_log2_o) && $stable(pos_ext_sel_o) && $stable(neg_auto_o) && !step_go_o)
    else $error("applied selects changed during conversion");

  skip_keeps_a: assert property (
    skip_step
    |=> $stable(gain_log2_o) && $stable(pos_ext_sel_o) && $stable(neg_auto_o) && !conv_busy_o)
    else $error("selects changed on a skipped step");

  unsure_code_a: assert property (
    start_conv && (cfg[asc_pkg::POS_HI:asc_pkg::POS_LO] == asc_pkg::POS_UNSURE_C)
    |=> pos_unsure_sel_o && neg_auto_o && pos_ext_sel_o == asc_pkg::EXT_NONE)
    else $error("unconfirmed supply code not flagged");

  write_mask_a: assert property (
    cfg_wr
    |=> (cfg & ~asc_pkg::WR_MASK) == asc_pkg::ZERO_WORD)
    else $error("reserved bits were written");

endmodule // asc_step_five_config

// ### asc_input_decode.sv
// constants package and input-select decoder for sequence step five
`timescale 1ns/10ps

package asc_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          EXT_N         = 8;
  localparam logic [7:0]  CFG_ADDR      = 8'h95;
  localparam logic [7:0]  APPLIED_ADDR  = 8'hF5;
  localparam int          EN_BIT        = 15;
  localparam int          GAIN_HI       = 14;
  localparam int          GAIN_LO       = 13;
  localparam int          RSV_HI        = 12;
  localparam int          RSV_LO        = 5;
  localparam int          NEG_BIT       = 4;
  localparam int          POS_HI        = 3;
  localparam int          POS_LO        = 0;
  localparam logic [15:0] CFG_RST       = 16'h0005;
  localparam logic [15:0] APPLIED_RST   = 16'h0000;
  localparam logic [15:0] WR_MASK       = 16'hE01F;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [3:0]  POS_INT_MIN   = 4'h8;
  localparam logic [3:0]  POS_TEMP      = 4'h8;
  localparam logic [3:0]  POS_SHORT     = 4'h9;
  localparam logic [3:0]  POS_TEST_DAC  = 4'hA;
  localparam logic [3:0]  POS_ASUP_DIV4 = 4'hB;
  localparam logic [3:0]  POS_UNSURE_C  = 4'hC;
  localparam logic [3:0]  POS_UNSURE_D  = 4'hD;
  localparam logic [3:0]  POS_APIN      = 4'hE;
  localparam logic [3:0]  POS_DPIN      = 4'hF;
  localparam logic [1:0]  GAIN_CODE_X1  = 2'h0;
  localparam logic [1:0]  GAIN_CODE_X2  = 2'h1;
  localparam logic [1:0]  GAIN_LOG2_X1  = 2'h0;
  localparam logic [1:0]  GAIN_LOG2_X2  = 2'h1;
  localparam logic [1:0]  GAIN_LOG2_X4  = 2'h2;
  localparam logic [7:0]  EXT_NONE      = 8'h00;
  localparam logic [7:0]  EXT_ONE       = 8'h01;
  typedef enum logic {ASC_IDLE, ASC_CONV} asc_state_t;
endpackage

module asc_input_decode (
  // step fields
  input  wire logic [3:0] pos_code_i,
  input  wire logic       neg_bit_i,
  // positive selects
  output wire logic [7:0] ext_sel_o,
  output wire logic       temp_sel_o,
  output wire logic       short_sel_o,
  output wire logic       test_dac_sel_o,
  output wire logic       asup_div4_sel_o,
  output wire logic       apin_sel_o,
  output wire logic       dpin_sel_o,
  output wire logic       unsure_sel_o,
  // negative selects
  output wire logic       neg_auto_o,
  output wire logic       neg_ground_sel_o,
  output wire logic       neg_input7_sel_o
);
  wire logic internal_src;
  assign internal_src     = pos_code_i >= asc_pkg::POS_INT_MIN;
  // external inputs 0..7 in order
  assign ext_sel_o        = internal_src ? asc_pkg::EXT_NONE
                          : (asc_pkg::EXT_ONE << pos_code_i[2:0]);
  assign temp_sel_o       = pos_code_i == asc_pkg::POS_TEMP;
  assign short_sel_o      = pos_code_i == asc_pkg::POS_SHORT;
  assign test_dac_sel_o   = pos_code_i == asc_pkg::POS_TEST_DAC;
  assign asup_div4_sel_o  = pos_code_i == asc_pkg::POS_ASUP_DIV4;
  assign apin_sel_o       = pos_code_i == asc_pkg::POS_APIN;
  assign dpin_sel_o       = pos_code_i == asc_pkg::POS_DPIN;
  assign unsure_sel_o     = (pos_code_i == asc_pkg::POS_UNSURE_C) || (pos_code_i == asc_pkg::POS_UNSURE_D);
  // negative input chosen automatically for internal sources
  assign neg_auto_o       = internal_src;
  assign neg_ground_sel_o = !internal_src && !neg_bit_i;
  assign neg_input7_sel_o = !internal_src && neg_bit_i;
endmodule // asc_input_decode

// ### tb_top.sv
// self-checking testbench for the step five configuration block
`timescale 1ns/10ps

module tb_top;
  logic        clk_i = 1'b0;
  logic        sys_rst_i;
  logic [7:0]  reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic        step_arrive_i;
  logic        conv_done_i;
  logic        step_go_o;
  logic        step_skip_o;
  logic        conv_busy_o;
  logic [1:0]  gain_log2_o;
  logic [7:0]  pos_ext_sel_o;
  logic        pos_temp_sel_o;
  logic        pos_short_sel_o;
  logic        pos_test_dac_sel_o;
  logic        pos_asup_div4_sel_o;
  logic        pos_apin_sel_o;
  logic        pos_dpin_sel_o;
  logic        pos_unsure_sel_o;
  logic        neg_auto_o;
  logic        neg_ground_sel_o;
  logic        neg_input7_sel_o;
  int          err_count;
  int          comparisons;
  logic [15:0] exp_sel;
  logic [3:0]  exp_neg;

  asc_step_five_config asc_step_five_config_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .step_arrive_i(step_arrive_i),
    .conv_done_i(conv_done_i), .step_go_o(step_go_o), .step_skip_o(step_skip_o), .conv_busy_o(conv_busy_o),
    .gain_log2_o(gain_log2_o), .pos_ext_sel_o(pos_ext_sel_o), .pos_temp_sel_o(pos_temp_sel_o),
    .pos_short_sel_o(pos_short_sel_o), .pos_test_dac_sel_o(pos_test_dac_sel_o),
    .pos_asup_div4_sel_o(pos_asup_div4_sel_o), .pos_apin_sel_o(pos_apin_sel_o), .pos_dpin_sel_o(pos_dpin_sel_o),
    .pos_unsure_sel_o(pos_unsure_sel_o), .neg_auto_o(neg_auto_o), .neg_ground_sel_o(neg_ground_sel_o),
    .neg_input7_sel_o(neg_input7_sel_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_o);
  endtask

  task automatic pulse_arrive();
    @(posedge clk_i);
    step_arrive_i <= 1'b1;
    @(posedge clk_i);
    step_arrive_i <= 1'b0;
    #1;
  endtask

  function automatic logic [15:0] sel_of(input logic [3:0] c);
    logic [7:0] ext;
    ext = (c < 4'h8) ? (8'h01 << c) : 8'h00;
    return {ext, c == 4'h8, c == 4'h9, c == 4'hA, c == 4'hB, c == 4'hE, c == 4'hF,
            c == 4'hC || c == 4'hD, c >= 4'h8};
  endfunction

  function automatic logic [3:0] neg_of(input logic [15:0] w);
    logic [1:0] g;
    g = (w[14:13] == 2'h0) ? 2'h0 : (w[14:13] == 2'h1) ? 2'h1 : 2'h2;
    return {w[3:0] < 4'h8 && !w[4], w[3:0] < 4'h8 && w[4], g};
  endfunction

  task automatic chk_applied();
    chk("pos selects", exp_sel, {pos_ext_sel_o, pos_temp_sel_o, pos_short_sel_o, pos_test_dac_sel_o,
        pos_asup_div4_sel_o, pos_apin_sel_o, pos_dpin_sel_o, pos_unsure_sel_o, neg_auto_o});
    chk("neg and gain", {12'h000, exp_neg}, {12'h000, neg_ground_sel_o, neg_input7_sel_o, gain_log2_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // write a word, run one step visit, judge go or skip and the applied selects
  task automatic run_step(input logic [15:0] w);
    wr(8'h95, w);
    pulse_arrive();
    chk("go", {15'h0, w[15]}, {15'h0, step_go_o});
    chk("skip", {15'h0, !w[15]}, {15'h0, step_skip_o});
    chk("busy", {15'h0, w[15]}, {15'h0, conv_busy_o});
    if (w[15])
    begin
      exp_sel = sel_of(w[3:0]);
      exp_neg = neg_of(w);
    end
    chk_applied();
    if (w[15])
    begin
      rd(8'hF5, w & 16'hE01F);
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      #1;
      chk("busy after done", 16'h0000, {15'h0, conv_busy_o});
    end
  endtask

  task automatic reset_values();
    rd(8'h95, 16'h0005);
    rd(8'hF5, 16'h0000);
    rd(8'h33, 16'h0000);
    exp_sel = 16'h0000;
    exp_neg = 4'h0;
    chk_applied();
  endtask

  task automatic reserved_bits();
    wr(8'h95, 16'hFFFF);
    rd(8'h95, 16'hE01F);
    wr(8'h40, 16'h0000);
    rd(8'h95, 16'hE01F);
  endtask

  task automatic gain_codes();
    for (int g = 0; g < 4; g++)
      run_step({1'b1, g[1:0], 8'h00, 1'b0, 4'h3});
  endtask

  task automatic pos_codes();
    for (int c = 0; c < 16; c++)
      run_step({1'b1, 2'h1, 8'h00, c[0], c[3:0]});
  endtask

  task automatic skip_keeps();
    run_step(16'h0011);
  endtask

  task automatic busy_holds();
    wr(8'h95, 16'h8002);
    pulse_arrive();
    exp_sel = sel_of(4'h2);
    exp_neg = neg_of(16'h8002);
    wr(8'h95, 16'hA013);
    pulse_arrive();
    chk("go while busy", 16'h0000, {15'h0, step_go_o | step_skip_o});
    chk("busy while conv", 16'h0001, {15'h0, conv_busy_o});
    chk_applied();
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    run_step(16'hA013);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    step_arrive_i = 1'b0;
    conv_done_i = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    reset_values();
    reserved_bits();
    gain_codes();
    pos_codes();
    skip_keeps();
    busy_holds();
    final_report();
  end

  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
endmodule // tb_top
